// ---- hw/mon_int_cfg.svh ----
// Constants for the monitor interrupt and control-output block.
// Assumes a 50 MHz system clock and a 32-bit Avalon-MM register port.
`ifndef MON_INT_CFG_SVH
`define MON_INT_CFG_SVH

`define CLK_HZ 50000000
`define PULSE_MS 20
`define PULSE_CYC ((`CLK_HZ / 1000) * `PULSE_MS)
`define PULSE_CW 20
`define POST_DEPTH 32

// Word-aligned byte addresses of the register map.
`define ADDR_CFG 8'h00
`define ADDR_STAT1 8'h04
`define ADDR_STAT2 8'h08
`define ADDR_MGMT_MASK1 8'h0C
`define ADDR_MGMT_MASK2 8'h10
`define ADDR_HOST_MASK1 8'h14
`define ADDR_HOST_MASK2 8'h18
`define ADDR_POST_PORT0 8'h1C
`define ADDR_POST_PORT4 8'h20
`define ADDR_POST_INDEX 8'h24
`define ADDR_POST_DATA 8'h28
`define ADDR_POST_WPTR 8'h2C

`define CFG_RESET 8'h08
`define MASK_RESET 8'h00
`define HOST_MASK2_RESET 8'h40

`define CFG_START 0
`define CFG_MGMT_EN 1
`define CFG_HOST_EN 2
`define CFG_INT_CLEAR 3
`define CFG_RST_PULSE 4
`define CFG_HOST_MODE 5
`define CFG_BYPASS 6
`define MASK2_PULSE_BIT 7

// Status register 2 bit positions.
`define ST2_POST_OVF 0
`define ST2_OVERTEMP 1
`define ST2_INTRUSION 2
`define ST2_CHAINED 3
`endif

// ---- hw/mon_int_pkg.sv ----
// Types shared by the monitor interrupt block.
// Assumes the constants header is compiled alongside.
package mon_int_pkg;
	typedef struct packed {
		logic [7:0] volt;
		logic [2:0] temp;
		logic [2:0] fan;
	} limit_viol_s;

	typedef struct packed {
		logic host_int_n;
		logic mgmt_int_n;
		logic bypass_n;
	} ctrl_out_s;

	typedef enum logic [1:0] {
		PULSE_IDLE = 2'b00,
		PULSE_LOW = 2'b01,
		PULSE_DONE = 2'b11
	} pulse_e;
endpackage

// ---- hw/monitor_interrupt_control.sv ----
// Interrupt collection, masking, timed pin pulses and POST code RAM of a hardware monitor.
// Assumes limit pulses come from comparators on i_clk_sys; pins are asynchronous.
//
// Function
// R1 - Any voltage, temperature or fan limit violation raises an interrupt.
// R2 - Writing more than 32 POST bytes raises an interrupt.
// R3 - Low level on overtemperature input is an interrupt source.
// R4 - High level on chassis intrusion input is an interrupt source.
// R5 - Host mask 2 bit 7 pulses intrusion line low 20 ms, then self-clears.
// R6 - Active-low chained interrupt input feeds the management interrupt path.
// R7 - Two status registers; each output has its own per-source mask set.
// R8 - Configuration enables each output and selects host output mode.
// R9 - Reading a status register returns contents then clears it.
// R10 - Software waits 1.5 s between status reads.
// R11 - Cleared status deasserts the output until the loop updates it.
// R12 - Configuration bit 3 holds outputs cleared and stops the monitoring loop.
// R13 - Configuration bit 6 drives bypass output low.
// R14 - Reset pulse works only with management mask 2 bit 7 set.
// R15 - Configuration bit 4 pulses reset output low 20 ms, then self-clears.
// R16 - POST port writes store bytes; pointer stops after 32.
// R17 - POST RAM readable by index/data; separate auto-increment read pointer.
// R18 - NAND test mode: start low, clear high, management output forced low.
// R19 - In NAND test mode any tree pin toggle toggles the test output; code NANDs all eight pins, so only while the other seven are high.
// R20 - Output asserts when enabled and an unmasked status bit is set.
//
// Design decisions made here: the register offsets and the Avalon-MM slave port.
`timescale 1ns/1ps
`include "mon_int_cfg.svh"
module monitor_interrupt_control (
	input wire logic i_clk_sys,
	input wire logic i_rstn,
	input wire logic [7:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [31:0] i_avs_writedata,
	input wire logic [3:0] i_avs_byteenable,
	output logic [31:0] o_avs_readdata,
	output logic o_avs_waitrequest,
	input wire mon_int_pkg::limit_viol_s i_limit_viol,
	input wire logic i_ext_overtemp_in_n,
	input wire logic i_intrusion_in,
	input wire logic i_chained_int_in_n,
	input wire logic i_mgmt_int_pin_in,
	input wire logic [7:0] i_tree_pins,
	output logic o_intrusion_oe,
	output logic o_intrusion_out,
	output logic o_reset_oe,
	output logic o_reset_out,
	output logic o_mgmt_int_out_n,
	output logic o_mgmt_int_oe,
	output logic o_host_int_n,
	output logic o_bypass_n,
	output logic o_loop_run,
	output logic o_nand_test_out
);
	import mon_int_pkg::*;

	////////////////////////////////////////////////////////////////////////
	function automatic logic [`PULSE_CW-1:0] pulse_count(input logic [`PULSE_CW-1:0] c, input logic run);
		pulse_count = run ? c + 20'h00001 : 20'h00000;
	endfunction

	// A read drops only the bits it handed out, so an event that lands while the read is in flight survives.
	function automatic logic [7:0] status_next(input logic [7:0] cur, input logic clr, input logic [7:0] taken,
		input logic [7:0] ev);
		status_next = (clr ? cur & ~taken : cur) | ev;
	endfunction

	function automatic pulse_e pulse_next(input pulse_e st, input logic go, input logic done);
		case (st)
			PULSE_IDLE: pulse_next = go ? PULSE_LOW : PULSE_IDLE;
			PULSE_LOW: pulse_next = done ? PULSE_DONE : PULSE_LOW;
			PULSE_DONE: pulse_next = PULSE_IDLE;
			default: pulse_next = PULSE_IDLE;
		endcase
	endfunction

	logic [2:0] ot_sync, ci_sync, ch_sync, mg_sync;
	logic [7:0] tree_s1, tree_s2;
	logic [7:0] cfg, stat1, stat2, mgmt_mask1, mgmt_mask2, host_mask1, host_mask2;
	logic [7:0] post_ram [0:`POST_DEPTH-1];
	logic [5:0] post_wptr;
	logic [4:0] post_rptr;
	logic [`PULSE_CW-1:0] ci_cnt, rst_cnt;
	pulse_e ci_st, rst_st;
	logic ack;
	logic nand_mode;
	logic [31:0] rdata;

	// Only the last stage of each synchroniser is read.
	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			ot_sync <= 3'h7;
			ci_sync <= 3'h0;
			ch_sync <= 3'h7;
			mg_sync <= 3'h7;
			tree_s1 <= 8'hFF;
			tree_s2 <= 8'hFF;
		end else begin
			ot_sync <= {ot_sync[1:0], i_ext_overtemp_in_n};
			ci_sync <= {ci_sync[1:0], i_intrusion_in};
			ch_sync <= {ch_sync[1:0], i_chained_int_in_n};
			mg_sync <= {mg_sync[1:0], i_mgmt_int_pin_in};
			tree_s1 <= i_tree_pins;
			tree_s2 <= tree_s1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Bus decode. Every access completes in the cycle after it is first seen.
	wire access = i_avs_read | i_avs_write;
	wire wr = i_avs_write & ack & i_avs_byteenable[0];
	wire rd = i_avs_read & ack;
	wire [7:0] wbyte = i_avs_writedata[7:0];
	wire wr_cfg = wr && i_avs_address == `ADDR_CFG;
	wire wr_mm1 = wr && i_avs_address == `ADDR_MGMT_MASK1;
	wire wr_mm2 = wr && i_avs_address == `ADDR_MGMT_MASK2;
	wire wr_hm1 = wr && i_avs_address == `ADDR_HOST_MASK1;
	wire wr_hm2 = wr && i_avs_address == `ADDR_HOST_MASK2;
	wire wr_post = wr && (i_avs_address == `ADDR_POST_PORT0 || i_avs_address == `ADDR_POST_PORT4);
	wire wr_idx = wr && i_avs_address == `ADDR_POST_INDEX;
	wire acc_data = (rd | wr) && i_avs_address == `ADDR_POST_DATA;
	wire rd_st1 = rd && i_avs_address == `ADDR_STAT1;
	wire rd_st2 = rd && i_avs_address == `ADDR_STAT2;
	assign o_avs_waitrequest = access & ~ack;

	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			ack <= 1'b0;
		end else begin
			ack <= access & ~ack;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// R12 loop halt
	assign o_loop_run = ~cfg[`CFG_INT_CLEAR];
	// R18 test entry
	assign nand_mode = ~cfg[`CFG_START] & cfg[`CFG_INT_CLEAR] & ~mg_sync[2];

	// R1 limit sources
	wire [7:0] ev1 = i_limit_viol.volt[7:0] & {8{o_loop_run}};
	// R2 POST overflow
	wire post_ovf = wr_post && post_wptr == 6'(`POST_DEPTH);
	// R3 R4 R6 external sources
	wire [7:0] ev2 = {1'b0, i_limit_viol.temp[2:0] & {3{o_loop_run}}, ~ch_sync[2], ci_sync[2], ~ot_sync[2], post_ovf};

	// R7 R9 status
	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			stat1 <= 8'h00;
			stat2 <= 8'h00;
		end else begin
			// R9 clear on read, new event wins
			stat1 <= status_next(stat1, rd_st1, o_avs_readdata[7:0], ev1);
			stat2 <= status_next(stat2, rd_st2, o_avs_readdata[7:0], ev2);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Fan events share status 1 upper bits with voltage bits 5..7 folded in.
	wire [7:0] fan_ev = {i_limit_viol.fan, 5'h00} & {8{o_loop_run}};
	logic [7:0] stat1_fan;
	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			stat1_fan <= 8'h00;
		end else begin
			stat1_fan <= status_next(stat1_fan, rd_st1, o_avs_readdata[7:0], fan_ev);
		end
	end
	wire [7:0] st1_all = stat1 | stat1_fan;

	// R20 R11 R8 output assert
	wire mgmt_req = |(st1_all & ~mgmt_mask1) | |(stat2[6:0] & ~mgmt_mask2[6:0]);
	wire host_req = |(st1_all & ~host_mask1) | |(stat2[6:0] & ~host_mask2[6:0]);
	wire mgmt_act = cfg[`CFG_MGMT_EN] & ~cfg[`CFG_INT_CLEAR] & mgmt_req;
	wire host_act = cfg[`CFG_HOST_EN] & ~cfg[`CFG_INT_CLEAR] & host_req;

	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			o_mgmt_int_out_n <= 1'b1;
			o_host_int_n <= 1'b1;
			o_bypass_n <= 1'b1;
		end else begin
			o_mgmt_int_out_n <= ~mgmt_act;
			// R8 host mode: low-active when mode bit clear, high-active otherwise
			o_host_int_n <= cfg[`CFG_HOST_MODE] ? host_act : ~host_act;
			// R13 bypass drive
			o_bypass_n <= ~cfg[`CFG_BYPASS];
		end
	end
	// Management line is open drain; it floats so a tester can force it in test mode.
	assign o_mgmt_int_oe = ~o_mgmt_int_out_n;

	////////////////////////////////////////////////////////////////////////
	// Control registers; self-clearing bits drop when their pulse ends.
	wire ci_done = ci_st == PULSE_LOW && ci_cnt == `PULSE_CW'(`PULSE_CYC - 1);
	wire rst_done = rst_st == PULSE_LOW && rst_cnt == `PULSE_CW'(`PULSE_CYC - 1);
	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			cfg <= `CFG_RESET;
			mgmt_mask1 <= `MASK_RESET;
			mgmt_mask2 <= `MASK_RESET;
			host_mask1 <= `MASK_RESET;
			host_mask2 <= `HOST_MASK2_RESET;
		end else begin
			if (wr_cfg) begin
				cfg <= wbyte;
			end else if (rst_done) begin
				// R15 self clear
				cfg[`CFG_RST_PULSE] <= 1'b0;
			end
			if (wr_mm1) mgmt_mask1 <= wbyte;
			if (wr_mm2) mgmt_mask2 <= wbyte;
			if (wr_hm1) host_mask1 <= wbyte;
			if (wr_hm2) begin
				host_mask2 <= wbyte;
			end else if (ci_done) begin
				// R5 self clear
				host_mask2[`MASK2_PULSE_BIT] <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// R5 R14 R15 pulse timers
	wire ci_go = host_mask2[`MASK2_PULSE_BIT];
	wire rst_go = cfg[`CFG_RST_PULSE] & mgmt_mask2[`MASK2_PULSE_BIT];
	pulse_e next_ci_st;
	pulse_e next_rst_st;
	assign next_ci_st = pulse_next(ci_st, ci_go, ci_done);
	assign next_rst_st = pulse_next(rst_st, rst_go, rst_done);
	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			ci_st <= PULSE_IDLE;
			rst_st <= PULSE_IDLE;
			ci_cnt <= 20'h00000;
			rst_cnt <= 20'h00000;
			o_intrusion_oe <= 1'b0;
			o_reset_oe <= 1'b0;
		end else begin
			ci_cnt <= pulse_count(ci_cnt, ci_st == PULSE_LOW);
			rst_cnt <= pulse_count(rst_cnt, rst_st == PULSE_LOW);
			ci_st <= next_ci_st;
			rst_st <= next_rst_st;
			// The pin enables come from flops, so a two-bit state step can never glitch a line low.
			o_intrusion_oe <= next_ci_st == PULSE_LOW;
			o_reset_oe <= next_rst_st == PULSE_LOW;
		end
	end
	assign o_intrusion_out = 1'b0;
	assign o_reset_out = 1'b0;

	////////////////////////////////////////////////////////////////////////
	// R16 POST write pointer
	always_ff @(posedge i_clk_sys) begin
		if (wr_post && post_wptr < 6'(`POST_DEPTH)) post_ram[post_wptr[4:0]] <= wbyte;
	end
	// R17 separate read pointer
	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			post_wptr <= 6'h00;
			post_rptr <= 5'h00;
		end else begin
			if (wr_post && post_wptr < 6'(`POST_DEPTH)) post_wptr <= post_wptr + 6'h01;
			if (wr_idx) begin
				post_rptr <= wbyte[4:0];
			end else if (acc_data && post_rptr != 5'h1F) begin
				post_rptr <= post_rptr + 5'h01;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read data mux; unmapped addresses read zero.
	always_comb begin
		rdata = 32'h00000000;
		case (i_avs_address)
			`ADDR_CFG: rdata[7:0] = cfg;
			`ADDR_STAT1: rdata[7:0] = st1_all;
			`ADDR_STAT2: rdata[7:0] = stat2;
			`ADDR_MGMT_MASK1: rdata[7:0] = mgmt_mask1;
			`ADDR_MGMT_MASK2: rdata[7:0] = mgmt_mask2;
			`ADDR_HOST_MASK1: rdata[7:0] = host_mask1;
			`ADDR_HOST_MASK2: rdata[7:0] = host_mask2;
			`ADDR_POST_INDEX: rdata[4:0] = post_rptr;
			`ADDR_POST_DATA: rdata[7:0] = post_ram[post_rptr];
			`ADDR_POST_WPTR: rdata[5:0] = post_wptr;
			default: rdata = 32'h00000000;
		endcase
	end

	// R19 NAND tree
	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			o_avs_readdata <= 32'h00000000;
			o_nand_test_out <= 1'b0;
		end else begin
			o_avs_readdata <= (i_avs_read & ~ack) ? rdata : o_avs_readdata;
			o_nand_test_out <= nand_mode & ~(&tree_s2);
		end
	end
endmodule

// ---- sim/host_pins.sv ----
// Host-side pin model: pull-ups on the open-drain lines and a tester hold.
// Assumes the bench feeds back the resolved levels to the block.
`timescale 1ns/1ps
module host_pins (
	input wire logic i_mgmt_oe,
	input wire logic i_intr_oe,
	input wire logic i_reset_oe,
	input wire logic i_force_low,
	output logic o_mgmt_pin,
	output logic o_intr_pin,
	output logic o_reset_pin
);
	assign o_mgmt_pin = !(i_mgmt_oe | i_force_low);
	// Released lines float up to the pull-up, never the last driven level.
	assign o_intr_pin = !i_intr_oe;
	assign o_reset_pin = !i_reset_oe;
endmodule

// ---- sim/mic_properties.sv ----
// Port-level properties of the monitor interrupt block.
// Assumes a single clock domain and the constants header.
`timescale 1ns/1ps
`include "mon_int_cfg.svh"
module mic_properties (
	input wire logic i_clk_sys,
	input wire logic i_rstn,
	input wire logic [7:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [31:0] i_avs_writedata,
	input wire logic [3:0] i_avs_byteenable,
	input wire logic o_avs_waitrequest,
	input wire logic o_intrusion_oe,
	input wire logic o_intrusion_out,
	input wire logic o_reset_oe,
	input wire logic o_mgmt_int_out_n,
	input wire logic o_mgmt_int_oe,
	input wire logic o_bypass_n,
	input wire logic o_loop_run
);
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (!i_rstn);
	logic [7:0] cfg;
	logic mask7;
	wire ack = i_avs_write && !o_avs_waitrequest && i_avs_byteenable[0];
	wire cfg_wr = ack && i_avs_address == `ADDR_CFG;
	// Shadow bit 4 is not cleared, so only the steady bits are used.
	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			cfg <= `CFG_RESET;
			mask7 <= 1'b0;
		end else if (ack) begin
			if (i_avs_address == `ADDR_CFG) cfg <= i_avs_writedata[7:0];
			if (i_avs_address == `ADDR_MGMT_MASK2) mask7 <= i_avs_writedata[7];
		end
	end
	a_wait_first: assert property ($rose(i_avs_read | i_avs_write) |-> o_avs_waitrequest)
		else $error("waitrequest low in first cycle");
	a_wait_ack: assert property ((i_avs_read | i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest)
		else $error("waitrequest held too long");
	a_loop_halt: assert property (o_loop_run == !cfg[3])
		else $error("loop run disagrees with config");
	a_int_halt: assert property (!o_loop_run && $past(!o_loop_run) |-> o_mgmt_int_out_n)
		else $error("interrupt active while halted");
	a_bypass_cfg: assert property ($changed(cfg[6]) |-> ##[1:2] o_bypass_n == !cfg[6])
		else $error("bypass level wrong");
	a_mgmt_drive: assert property (!cfg[1] && $past(!cfg[1]) |-> o_mgmt_int_out_n && !o_mgmt_int_oe)
		else $error("interrupt driven while disabled");
	a_intr_start: assert property (ack && i_avs_address == `ADDR_HOST_MASK2 && i_avs_writedata[7]
		|-> ##[1:2] o_intrusion_oe && !o_intrusion_out)
		else $error("intrusion pulse missing");
	a_rst_gate: assert property ($rose(o_reset_oe) |-> mask7)
		else $error("reset pulse without enable");
	a_rst_start: assert property (cfg_wr && i_avs_writedata[4] && mask7 |-> ##[1:2] o_reset_oe)
		else $error("reset pulse missing");
	c_post: cover property (ack && i_avs_address == `ADDR_POST_PORT0);
	c_intr: cover property ($rose(o_intrusion_oe));
	c_rst: cover property ($rose(o_reset_oe));
endmodule
bind monitor_interrupt_control mic_properties chk (.*);

// ---- sim/monitor_interrupt_control_tb.sv ----
// Self-checking bench for the monitor interrupt block.
// Assumes the host pin model and the bound property checker.
`timescale 1ns/1ps
`include "mon_int_cfg.svh"
module monitor_interrupt_control_tb;
	import mon_int_pkg::*;
	logic i_clk_sys = 0, i_rstn = 0, rd = 0, wr = 0, ot_n = 1, intr = 0, ch_n = 1, frc = 0;
	logic [7:0] adr = 8'h00, tree = 8'hFF, v, t, f;
	logic [7:0] d[33], q[$];
	logic [15:0] rt[9] = '{16'h0008, 16'h0400, 16'h0800, 16'h0C00, 16'h1000, 16'h1400, 16'h1840, 16'h2C00,
		16'h3C00};
	logic [31:0] wd = 32'h0;
	logic [16:0] lf = 17'h16D61;
	limit_viol_s lv = '0;
	wire [31:0] rdat;
	wire wq, ioe, iout, roe, rout, mo, moe, ho, bp, lr, nt, mpin, ipin, rpin;
	int bad_count = 0, checks = 0, i, k;
	monitor_interrupt_control dut (.i_clk_sys(i_clk_sys), .i_rstn(i_rstn), .i_avs_address(adr),
		.i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd), .i_avs_byteenable(4'hF),
		.o_avs_readdata(rdat), .o_avs_waitrequest(wq), .i_limit_viol(lv), .i_ext_overtemp_in_n(ot_n),
		.i_intrusion_in(intr & ipin), .i_chained_int_in_n(ch_n), .i_mgmt_int_pin_in(mpin), .i_tree_pins(tree),
		.o_intrusion_oe(ioe), .o_intrusion_out(iout), .o_reset_oe(roe), .o_reset_out(rout),
		.o_mgmt_int_out_n(mo), .o_mgmt_int_oe(moe), .o_host_int_n(ho), .o_bypass_n(bp), .o_loop_run(lr),
		.o_nand_test_out(nt));
	host_pins far (.i_mgmt_oe(moe), .i_intr_oe(ioe), .i_reset_oe(roe), .i_force_low(frc),
		.o_mgmt_pin(mpin), .o_intr_pin(ipin), .o_reset_pin(rpin));
	initial forever #10 i_clk_sys = ~i_clk_sys;
	function automatic logic [7:0] rnd();
		lf = {lf[15:0], lf[16] ^ lf[13]};
		return lf[7:0];
	endfunction
	task automatic check(input logic [31:0] g, e);
		checks++;
		if (g !== e) begin
			bad_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic print_verdict();
		$display("checks=%0d bad_count=%0d", checks, bad_count);
		if (bad_count == 0 && checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	// Every request starts after a rising edge and holds through the edge at which waitrequest is sampled low.
	task automatic bus(input logic w, input logic [7:0] a, dt);
		int n;
		@(posedge i_clk_sys);
		rd <= !w;
		wr <= w;
		adr <= a;
		wd <= {24'h0, dt};
		for (n = 0; n < 50; n++) begin
			@(posedge i_clk_sys);
			if (wq === 1'b0) break;
		end
		if (n == 50) begin
			bad_count++;
			print_verdict();
		end
		rd <= 0;
		wr <= 0;
	endtask
	task automatic rdx(input logic [7:0] a, e);
		q.push_back(e);
		bus(0, a, 8'h00);
	endtask
	task automatic pause(input int n);
		repeat (n) @(negedge i_clk_sys);
	endtask
	// Read data is taken at the same edge at which waitrequest is sampled low.
	always @(posedge i_clk_sys)
		if (rd === 1'b1 && wq === 1'b0) check(rdat, {24'h0, q.pop_front()});
	initial begin
		repeat (3) @(posedge i_clk_sys);
		i_rstn <= 1;
		for (i = 0; i < 9; i++) rdx(rt[i][15:8], rt[i][7:0]);
		check(bp, 1);
		bus(1, 8'h00, 8'h07);
		pause(1);
		check(lr, 1);
		v = rnd() | 8'h01;
		t = rnd() & 8'h07;
		f = rnd() & 8'h07;
		@(posedge i_clk_sys);
		lv <= {v, t[2:0], f[2:0]};
		@(posedge i_clk_sys);
		lv <= '0;
		pause(3);
		check({mo, ho}, 0);
		rdx(8'h04, {v[7:5] | f[2:0], v[4:0]});
		rdx(8'h08, {t[3:0], 4'h0});
		pause(3);
		check({mo, ho}, 3);
		rdx(8'h04, 8'h00);
		// A full first mask keeps the management line quiet for volt events.
		bus(1, 8'h0C, 8'hFF);
		bus(1, 8'h00, 8'h27);
		@(posedge i_clk_sys);
		lv <= {8'h01, 6'h00};
		@(posedge i_clk_sys);
		lv <= '0;
		pause(3);
		check({mo, ho}, 3);
		rdx(8'h04, 8'h01);
		pause(3);
		check(ho, 0);
		for (i = 0; i < 3; i++) begin
			@(posedge i_clk_sys);
			{ot_n, intr, ch_n} <= {i != 0, i == 1, i != 2};
			pause(6);
			check(mo, 0);
			@(posedge i_clk_sys);
			{ot_n, intr, ch_n} <= 3'b101;
			pause(6);
			rdx(8'h08, 8'h01 << (i + 1));
			rdx(8'h08, 8'h00);
		end
		for (i = 0; i < 33; i++) begin
			d[i] = rnd();
			bus(1, i[0] ? 8'h20 : 8'h1C, d[i]);
		end
		rdx(8'h2C, 8'h20);
		rdx(8'h08, 8'h01);
		bus(1, 8'h24, 8'h00);
		for (i = 0; i < 33; i++) rdx(8'h28, d[i < 32 ? i : 31]);
		bus(1, 8'h00, 8'h57);
		pause(3);
		check({bp, roe}, 0);
		rdx(8'h00, 8'h57);
		bus(1, 8'h10, 8'h80);
		bus(1, 8'h00, 8'h17);
		pause(3);
		check({roe, rout, rpin, bp}, 4'b1001);
		bus(1, 8'h18, 8'hC0);
		pause(3);
		check({ioe, iout, ipin}, 3'b100);
		rdx(8'h18, 8'hC0);
		@(posedge i_clk_sys);
		i_rstn <= 0;
		repeat (3) @(posedge i_clk_sys);
		i_rstn <= 1;
		tree <= 8'hFE;
		// Each toggle settles within 200 ns, ten cycles at this clock.
		pause(10);
		check({nt, lr}, 0);
		@(posedge i_clk_sys);
		frc <= 1;
		pause(10);
		check(nt, 1);
		@(posedge i_clk_sys);
		tree <= 8'hFF;
		pause(10);
		check(nt, 0);
		for (k = 0; k < 8; k++) begin
			@(posedge i_clk_sys);
			tree <= 8'hFF ^ (8'h01 << k);
			pause(10);
			check(nt, 1);
			@(posedge i_clk_sys);
			tree <= 8'hFF;
			pause(10);
			check(nt, 0);
		end
		print_verdict();
	end
endmodule
